/* File: rxmi_top.sv */
`timescale 1ns/10ps
// How it works
// - Bit 10 set when any error of bits 7 or 11-15 arose.
// - Bit 9 set when answered busy, by global or per-subaddress busy bit.
// - Data words are still stored while answering busy.
// - Bit 8 set when the illegal table entry for the command is one.
// - Bit 7 set if second command is broadcast or has T/R zero.
// - Bit 7 set if second command is a mode code or repeats our address.
// - Bit 7 set if transmitter status is invalid or its address mismatches.
// - Bit 6 set only for an error-free RT-to-RT receive.
// - Bit 5 is zero for bus A, one for bus B.
// - Bits 4-0 copy the command word count; zero means thirty-two.
// - Info word at the pointer, time tag next, then the data words.
// - After a message error no further data words are stored.
// - Bit 14 set when a data word has a Manchester or parity error.
module rxmi_top #(
  parameter int AW = 13
) (
  input logic hclk,
  input logic hresetn,
  input logic ce,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input logic msg_start,
  input logic [15:0] first_command_word,
  input logic [15:0] second_command_word,
  input logic is_rt_to_rt,
  input logic bus_b,
  input logic [AW-1:0] data_ptr,
  input logic [15:0] time_tag,
  input logic rx_data_stb,
  input logic [15:0] rx_data,
  input logic rx_data_err,
  input logic tx_stat_stb,
  input logic tx_stat_valid,
  input logic [15:0] tx_stat_word,
  input logic err_timeout,
  input logic err_gap,
  input logic err_wcount,
  input logic err_sync,
  input logic msg_end,
  output logic mem_we,
  output logic [AW-1:0] mem_addr,
  output logic [15:0] mem_wdata,
  output logic irq
);
  // All checks sample on the bus clock
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic rd_take;
  logic [7:0] rd_addr;
  logic [7:0] wr_addr;
  logic wr_act, tx_cmd_err;

  rxmi_ahb_front u_front (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .rd_take(rd_take),
    .rd_addr(rd_addr),
    .wr_act(wr_act),
    .wr_addr(wr_addr)
  );

  rxmi_tx_cmd_chk u_tx_cmd (
    .first_command_word(first_command_word),
    .second_command_word(second_command_word),
    .tx_err(tx_cmd_err)
  );

  // Message state
  rxmi_pkg::rxmi_state_e state_q, state_d;
  logic [15:0] acc_q, acc_d;
  logic rt_to_rt_q, rt_to_rt_d;
  logic [4:0] exp_rt_q, exp_rt_d;
  logic [AW-1:0] ptr_q, ptr_d;
  logic [5:0] wcnt_q, wcnt_d;
  logic [15:0] tag_q, tag_d, mem_wdata_q, mem_wdata_d, info;
  logic mem_we_q, mem_we_d;
  logic [AW-1:0] mem_addr_q, mem_addr_d;
  logic info_wr_q, info_wr_d;
  logic msg_err, done_ev, err_ev;
  logic [4:0] sa1;

  // Register file state
  logic gbusy_q, gbusy_d, irq_q, irq_d, hreadyout_q;
  logic [31:0] ill_q, ill_d, btbl_q, btbl_d, hrdata_q, hrdata_d;
  logic [1:0] istat_q, istat_d, imask_q, imask_d;
  logic [15:0] last_q, last_d, count_q, count_d;

  // Read data multiplexer
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    unique case (a)
      rxmi_pkg::OFS_CTRL: return {31'h0000_0000, gbusy_q};
      rxmi_pkg::OFS_ILLEGAL: return ill_q;
      rxmi_pkg::OFS_BUSY_TBL: return btbl_q;
      rxmi_pkg::OFS_IRQ_STAT: return {30'h0000_0000, istat_q};
      rxmi_pkg::OFS_IRQ_MASK: return {30'h0000_0000, imask_q};
      rxmi_pkg::OFS_LAST_INFO: return {16'h0000, last_q};
      rxmi_pkg::OFS_MSG_COUNT: return {16'h0000, count_q};
      default: return 32'h0000_0000;
    endcase
  endfunction : reg_read

  // Message sequencer and information word builder
  always_comb begin
    state_d = state_q;
    acc_d = acc_q;
    rt_to_rt_d = rt_to_rt_q;
    exp_rt_d = exp_rt_q;
    ptr_d = ptr_q;
    wcnt_d = wcnt_q;
    tag_d = tag_q;
    mem_we_d = 1'b0;
    mem_addr_d = mem_addr_q;
    mem_wdata_d = mem_wdata_q;
    info_wr_d = 1'b0;
    msg_err = 1'b0;
    done_ev = 1'b0;
    err_ev = 1'b0;
    info = acc_q;
    sa1 = rxmi_pkg::sub_addr(first_command_word);
    unique case (state_q)
      rxmi_pkg::ST_IDLE: begin
        if (msg_start) begin
          state_d = rxmi_pkg::ST_RECV;
          acc_d = rxmi_pkg::RST_WORD;
          acc_d[rxmi_pkg::WC_MSB:0] = first_command_word[4:0];
          acc_d[rxmi_pkg::B_BUS_SEL] = bus_b;
          acc_d[rxmi_pkg::B_BUSY] = gbusy_q | btbl_q[sa1];
          acc_d[rxmi_pkg::B_ILLEGAL] = ill_q[sa1];
          acc_d[rxmi_pkg::B_TX_ERR] = is_rt_to_rt & tx_cmd_err;
          rt_to_rt_d = is_rt_to_rt;
          exp_rt_d = rxmi_pkg::rt_addr(second_command_word);
          ptr_d = data_ptr;
          wcnt_d = 6'h00;
          tag_d = time_tag;
        end
      end
      rxmi_pkg::ST_RECV: begin
        // Sticky error flags over the whole message
        acc_d[rxmi_pkg::B_TIMEOUT] = acc_q[rxmi_pkg::B_TIMEOUT] | err_timeout;
        acc_d[rxmi_pkg::B_INVALID_WORD] = acc_q[rxmi_pkg::B_INVALID_WORD]
          | (rx_data_stb & rx_data_err);
        acc_d[rxmi_pkg::B_GAP] = acc_q[rxmi_pkg::B_GAP] | err_gap;
        acc_d[rxmi_pkg::B_WCOUNT] = acc_q[rxmi_pkg::B_WCOUNT] | err_wcount;
        acc_d[rxmi_pkg::B_SYNC] = acc_q[rxmi_pkg::B_SYNC] | err_sync;
        if (tx_stat_stb && rt_to_rt_q && (!tx_stat_valid
            || rxmi_pkg::rt_addr(tx_stat_word) != exp_rt_q)) begin
          acc_d[rxmi_pkg::B_TX_ERR] = 1'b1;
        end
        msg_err = (|acc_d[15:11]) | acc_d[rxmi_pkg::B_TX_ERR];
        info = acc_d;
        info[rxmi_pkg::B_MSG_ERR] = msg_err;
        info[rxmi_pkg::B_RT_TO_RT] = rt_to_rt_q & ~msg_err;
        if (msg_end) begin
          // Whole word written once, at the record start
          state_d = rxmi_pkg::ST_TAG;
          mem_we_d = 1'b1;
          mem_addr_d = ptr_q;
          mem_wdata_d = info;
          info_wr_d = 1'b1;
          done_ev = 1'b1;
          err_ev = msg_err;
        end else if (rx_data_stb && !msg_err) begin
          // Busy answers still store the data
          mem_we_d = 1'b1;
          mem_addr_d = ptr_q + AW'(rxmi_pkg::DATA_OFS) + AW'(wcnt_q);
          mem_wdata_d = rx_data;
          wcnt_d = wcnt_q + 6'h01;
        end
      end
      rxmi_pkg::ST_TAG: begin
        state_d = rxmi_pkg::ST_IDLE;
        mem_we_d = 1'b1;
        mem_addr_d = ptr_q + AW'(rxmi_pkg::TAG_OFS);
        mem_wdata_d = tag_q;
      end
      default: state_d = rxmi_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= rxmi_pkg::ST_IDLE;
      acc_q <= rxmi_pkg::RST_WORD;
      rt_to_rt_q <= 1'b0;
      exp_rt_q <= 5'h00;
      ptr_q <= '0;
      wcnt_q <= 6'h00;
      tag_q <= rxmi_pkg::RST_WORD;
      mem_we_q <= 1'b0;
      mem_addr_q <= '0;
      mem_wdata_q <= rxmi_pkg::RST_WORD;
      info_wr_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      acc_q <= acc_d;
      rt_to_rt_q <= rt_to_rt_d;
      exp_rt_q <= exp_rt_d;
      ptr_q <= ptr_d;
      wcnt_q <= wcnt_d;
      tag_q <= tag_d;
      mem_we_q <= mem_we_d;
      mem_addr_q <= mem_addr_d;
      mem_wdata_q <= mem_wdata_d;
      info_wr_q <= info_wr_d;
    end
  end

  // Register writes, read-clear status, interrupt
  always_comb begin
    gbusy_d = gbusy_q;
    ill_d = ill_q;
    btbl_d = btbl_q;
    imask_d = imask_q;
    istat_d = istat_q;
    last_d = done_ev ? info : last_q;
    count_d = done_ev ? count_q + 16'h0001 : count_q;
    if (wr_act) begin
      unique case (wr_addr)
        rxmi_pkg::OFS_CTRL: gbusy_d = hwdata[0];
        rxmi_pkg::OFS_ILLEGAL: ill_d = hwdata;
        rxmi_pkg::OFS_BUSY_TBL: btbl_d = hwdata;
        rxmi_pkg::OFS_IRQ_MASK: imask_d = hwdata[1:0];
        default: ;
      endcase
    end
    if (rd_take && rd_addr == rxmi_pkg::OFS_IRQ_STAT) begin
      istat_d = 2'h0;
    end
    // A new event wins over the read clear
    istat_d[rxmi_pkg::IRQ_B_DONE] = istat_d[rxmi_pkg::IRQ_B_DONE] | done_ev;
    istat_d[rxmi_pkg::IRQ_B_ERR] = istat_d[rxmi_pkg::IRQ_B_ERR] | err_ev;
    irq_d = |(istat_d & imask_d);
    hrdata_d = rd_take ? reg_read(rd_addr) : hrdata_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gbusy_q <= rxmi_pkg::RST_GLOBAL_BUSY;
      ill_q <= rxmi_pkg::RST_TABLE;
      btbl_q <= rxmi_pkg::RST_TABLE;
      istat_q <= rxmi_pkg::RST_IRQ;
      imask_q <= rxmi_pkg::RST_IRQ;
      last_q <= rxmi_pkg::RST_WORD;
      count_q <= rxmi_pkg::RST_WORD;
      hrdata_q <= rxmi_pkg::RST_TABLE;
      irq_q <= 1'b0;
      hreadyout_q <= 1'b1;
    end else if (ce) begin
      gbusy_q <= gbusy_d;
      ill_q <= ill_d;
      btbl_q <= btbl_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      last_q <= last_d;
      count_q <= count_d;
      hrdata_q <= hrdata_d;
      irq_q <= irq_d;
      hreadyout_q <= 1'b1;
    end
  end

  // Outputs straight from flops, except hresp tied to zero
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign mem_we = mem_we_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign irq = irq_q;

  // Checks
  property p_msg_err;
    info_wr_q |-> mem_wdata_q[10] == ((|mem_wdata_q[15:11]) | mem_wdata_q[7]);
  endproperty
  a_msg_err: assert property (p_msg_err) else $error("message error bit wrong");
  property p_busy;
    ce && state_q == rxmi_pkg::ST_IDLE && msg_start
      && (gbusy_q || btbl_q[first_command_word[9:5]]) |=> acc_q[9];
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag not set");
  property p_busy_store;
    ce && state_q == rxmi_pkg::ST_RECV && acc_q[9] && rx_data_stb && !rx_data_err
      && !msg_end && !msg_err |=> mem_we_q && mem_wdata_q == $past(rx_data);
  endproperty
  a_busy_store: assert property (p_busy_store) else $error("busy data not stored");
  property p_illegal;
    ce && state_q == rxmi_pkg::ST_IDLE && msg_start
      |=> acc_q[8] == $past(ill_q[first_command_word[9:5]]);
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal flag wrong");
  property p_tx_cmd;
    ce && state_q == rxmi_pkg::ST_IDLE && msg_start && is_rt_to_rt
      && (second_command_word[15:11] == 5'h1f || !second_command_word[10]) |=> acc_q[7];
  endproperty
  a_tx_cmd: assert property (p_tx_cmd) else $error("transmit command error missed");
  property p_stat;
    ce && state_q == rxmi_pkg::ST_RECV && rt_to_rt_q && tx_stat_stb && !tx_stat_valid
      |=> acc_q[7];
  endproperty
  a_stat: assert property (p_stat) else $error("status error missed");
  property p_rt_to_rt;
    info_wr_q && mem_wdata_q[6] |-> !mem_wdata_q[10];
  endproperty
  a_rt_to_rt: assert property (p_rt_to_rt) else $error("rt-rt flag with error");
  property p_wc;
    ce && state_q == rxmi_pkg::ST_IDLE && msg_start
      |=> acc_q[4:0] == $past(first_command_word[4:0]) && acc_q[5] == $past(bus_b);
  endproperty
  a_wc: assert property (p_wc) else $error("count or bus bit wrong");
  property p_order;
    ce && info_wr_q |=> mem_we_q && mem_addr_q == $past(mem_addr_q) + AW'(1);
  endproperty
  a_order: assert property (p_order) else $error("time tag not after info");
  property p_no_data;
    ce && state_q == rxmi_pkg::ST_RECV && msg_err && !msg_end |=> !mem_we_q;
  endproperty
  a_no_data: assert property (p_no_data) else $error("data stored after error");

endmodule : rxmi_top

/* File: rxmi_pkg.sv */
package rxmi_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ILLEGAL = 8'h04;
  localparam logic [7:0] OFS_BUSY_TBL = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_LAST_INFO = 8'h14;
  localparam logic [7:0] OFS_MSG_COUNT = 8'h18;

  // Values after reset
  localparam logic RST_GLOBAL_BUSY = 1'b0;
  localparam logic [31:0] RST_TABLE = 32'h0000_0000;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Field positions of the information word
  localparam int B_TIMEOUT = 15;
  localparam int B_INVALID_WORD = 14;
  localparam int B_GAP = 13;
  localparam int B_WCOUNT = 12;
  localparam int B_SYNC = 11;
  localparam int B_MSG_ERR = 10;
  localparam int B_BUSY = 9;
  localparam int B_ILLEGAL = 8;
  localparam int B_TX_ERR = 7;
  localparam int B_RT_TO_RT = 6;
  localparam int B_BUS_SEL = 5;
  localparam int WC_MSB = 4;

  // Interrupt status bit positions
  localparam int IRQ_B_DONE = 0;
  localparam int IRQ_B_ERR = 1;

  // Record layout: info word, then time tag, then data
  localparam int TAG_OFS = 1;
  localparam int DATA_OFS = 2;

  // Special addresses and subaddresses
  localparam logic [4:0] RT_BROADCAST = 5'h1f;
  localparam logic [4:0] SA_MODE_LO = 5'h00;
  localparam logic [4:0] SA_MODE_HI = 5'h1f;

  typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_TAG} rxmi_state_e;

  // Command and status word fields
  function automatic logic [4:0] rt_addr(input logic [15:0] w);
    return w[15:11];
  endfunction : rt_addr

  function automatic logic [4:0] sub_addr(input logic [15:0] w);
    return w[9:5];
  endfunction : sub_addr

endpackage : rxmi_pkg

/* File: rxmi_cw2_chk.sv */
`timescale 1ns/10ps
module rxmi_tx_cmd_chk (
  input logic [15:0] first_command_word,
  input logic [15:0] second_command_word,
  output logic tx_err
);
  logic [4:0] rt2;
  logic [4:0] sa2;

  // Checks on the command to the transmitting terminal
  always_comb begin
    rt2 = rxmi_pkg::rt_addr(second_command_word);
    sa2 = rxmi_pkg::sub_addr(second_command_word);
    tx_err = (rt2 == rxmi_pkg::RT_BROADCAST)
      || !second_command_word[10]
      || (sa2 == rxmi_pkg::SA_MODE_LO) || (sa2 == rxmi_pkg::SA_MODE_HI)
      || (rt2 == rxmi_pkg::rt_addr(first_command_word));
  end
endmodule : rxmi_tx_cmd_chk

/* File: rxmi_ahb_front.sv */
`timescale 1ns/10ps
module rxmi_ahb_front (
  input logic hclk,
  input logic hresetn,
  input logic ce,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  output logic rd_take,
  output logic [7:0] rd_addr,
  output logic wr_act,
  output logic [7:0] wr_addr
);
  logic wr_take;
  logic wr_q;
  logic wr_d;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_addr_d;

  // Address phase decode, NONSEQ or SEQ
  always_comb begin
    rd_take = hsel && htrans[1] && !hwrite && hready;
    wr_take = hsel && htrans[1] && hwrite && hready;
    rd_addr = haddr[7:0];
    wr_d = wr_take;
    wr_addr_d = wr_take ? haddr[7:0] : wr_addr_q;
    wr_act = wr_q;
    wr_addr = wr_addr_q;
  end

  // Write held into its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (ce) begin
      wr_q <= wr_d;
      wr_addr_q <= wr_addr_d;
    end
  end
endmodule : rxmi_ahb_front

/* File: rxmi_bus_model.sv */
`timescale 1ns/10ps
// Bus controller and transmitting terminal seen by the receiving terminal
module rxmi_bus_model #(
  parameter int AW = 13
) (
  input wire logic hclk,
  output logic msg_start,
  output logic [15:0] first_command_word,
  output logic [15:0] second_command_word,
  output logic is_rt_to_rt,
  output logic bus_b,
  output logic [AW-1:0] data_ptr,
  output logic [15:0] time_tag,
  output logic rx_data_stb,
  output logic [15:0] rx_data,
  output logic rx_data_err,
  output logic tx_stat_stb,
  output logic tx_stat_valid,
  output logic [15:0] tx_stat_word,
  output logic [3:0] errs,
  output logic msg_end
);
  // Quiet lines at time zero
  initial begin
    {msg_start, rx_data_stb, tx_stat_stb, errs, msg_end} = '0;
    {first_command_word, second_command_word, is_rt_to_rt, bus_b} = '0;
    {data_ptr, time_tag, rx_data, rx_data_err, tx_stat_valid, tx_stat_word} = '0;
  end

  // Command words, then released lines show the inverse
  task automatic start(input logic [15:0] c1, input logic [15:0] c2, input logic rt,
      input logic bb, input logic [AW-1:0] p, input logic [15:0] t);
    @(posedge hclk);
    msg_start <= 1'b1;
    {first_command_word, second_command_word, is_rt_to_rt, bus_b, data_ptr, time_tag} <=
      {c1, c2, rt, bb, p, t};
    @(posedge hclk);
    msg_start <= 1'b0;
    {first_command_word, second_command_word, is_rt_to_rt, bus_b, data_ptr, time_tag} <=
      ~{c1, c2, rt, bb, p, t};
  endtask : start

  // One data word from the bus
  task automatic word(input logic [15:0] d, input logic e);
    @(posedge hclk);
    {rx_data_stb, rx_data, rx_data_err} <= {1'b1, d, e};
    @(posedge hclk);
    {rx_data_stb, rx_data, rx_data_err} <= {1'b0, ~d, ~e};
  endtask : word

  // Status word of the transmitting terminal
  task automatic stat(input logic v, input logic [15:0] w);
    @(posedge hclk);
    {tx_stat_stb, tx_stat_valid, tx_stat_word} <= {1'b1, v, w};
    @(posedge hclk);
    {tx_stat_stb, tx_stat_valid, tx_stat_word} <= {1'b0, ~v, ~w};
  endtask : stat

  // Optional fault pulses, end of message, then the required gap
  task automatic finish(input logic [3:0] f);
    if (f != 4'h0) begin
      @(posedge hclk);
      errs <= f;
      @(posedge hclk);
      errs <= 4'h0;
    end
    @(posedge hclk);
    msg_end <= 1'b1;
    @(posedge hclk);
    msg_end <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : finish
endmodule : rxmi_bus_model

/* File: test_rxmi_top.sv */
`timescale 1ns/10ps
module test_rxmi_top;
  localparam logic [12:0] PTR = 13'h0100;
  localparam logic [15:0] TAG = 16'h5a5a;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, mem_we;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic msg_start, is_rt_to_rt, bus_b, rx_data_stb, rx_data_err, tx_stat_stb;
  logic tx_stat_valid, msg_end;
  logic [15:0] cmd1, cmd2, time_tag, rx_data, tx_stat_word, mem_wdata;
  logic [12:0] data_ptr, mem_addr;
  logic [3:0] errs;
  logic [15:0] mem [0:8191];
  int fail_count = 0;
  int compares = 0;

  // Clock, one slave on the bus, captured RAM writes
  always #10 hclk = ~hclk;
  assign hready = hreadyout;
  always @(posedge hclk) if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;

  rxmi_bus_model #(.AW(13)) rxmi_bus_model_i (.hclk(hclk), .msg_start(msg_start),
    .first_command_word(cmd1), .second_command_word(cmd2), .is_rt_to_rt(is_rt_to_rt),
    .bus_b(bus_b), .data_ptr(data_ptr), .time_tag(time_tag), .rx_data_stb(rx_data_stb),
    .rx_data(rx_data), .rx_data_err(rx_data_err), .tx_stat_stb(tx_stat_stb),
    .tx_stat_valid(tx_stat_valid), .tx_stat_word(tx_stat_word), .errs(errs),
    .msg_end(msg_end));
  rxmi_top #(.AW(13)) rxmi_top_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .msg_start(msg_start), .first_command_word(cmd1), .second_command_word(cmd2),
    .is_rt_to_rt(is_rt_to_rt), .bus_b(bus_b), .data_ptr(data_ptr), .time_tag(time_tag),
    .rx_data_stb(rx_data_stb), .rx_data(rx_data), .rx_data_err(rx_data_err),
    .tx_stat_stb(tx_stat_stb), .tx_stat_valid(tx_stat_valid), .tx_stat_word(tx_stat_word),
    .err_timeout(errs[3]), .err_gap(errs[2]), .err_wcount(errs[1]), .err_sync(errs[0]),
    .msg_end(msg_end), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .irq(irq));

  function automatic logic [15:0] fl(input int b);
    return 16'h1 << b;
  endfunction : fl

  function automatic logic [15:0] cw(input logic [4:0] rt, input logic tr,
      input logic [4:0] sa, input logic [4:0] wc);
    return {rt, tr, sa, wc};
  endfunction : cw

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      fail_count++;
    end
  endtask : check

  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  // Wait for hready under a bound
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) check("hready", hready, 1'b1);
  endtask : wait_rdy

  // One AHB-Lite single word transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, 24'h0, a, wr};
    wait_rdy();
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    wait_rdy();
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check("hrdata", r, e);
    check("hresp", hresp, 1'b0);
  endtask : rdc

  // One receive message; word bad carries an error
  task automatic msg(input logic [15:0] c2, input logic rt, input logic bb,
      input logic [4:0] wc, input int n, input int bad, input logic sv,
      input logic [15:0] sw, input logic [3:0] f);
    for (int i = 0; i < 40; i++) mem[PTR + i] = 16'hdead;
    rxmi_bus_model_i.start(cw(5'h05, 1'b0, 5'h03, wc), c2, rt, bb, PTR, TAG);
    if (rt) rxmi_bus_model_i.stat(sv, sw);
    for (int i = 0; i < n; i++) rxmi_bus_model_i.word(16'(16'h1000 + i), i == bad);
    rxmi_bus_model_i.finish(f);
  endtask : msg

  // Record: info word, tag, kept data words, nothing after
  task automatic rec(input logic [15:0] info, input int kept);
    check("info word", mem[PTR], info);
    check("time tag", mem[PTR + 1], TAG);
    for (int i = 0; i < kept; i++) check("data word", mem[PTR + 2 + i], 16'(16'h1000 + i));
    check("word past record", mem[PTR + 2 + kept], 16'hdead);
  endtask : rec

  task automatic t_plain();
    msg(16'h0, 1'b0, 1'b0, 5'h03, 3, -1, 1'b0, 16'h0, 4'h0);
    rec(16'h0003, 3);
    rdc(rxmi_pkg::OFS_LAST_INFO, 32'h3);
    rdc(rxmi_pkg::OFS_MSG_COUNT, 32'h1);
    rdc(8'h40, 32'h0);
  endtask : t_plain

  task automatic t_faults();
    int fb [4] = '{15, 13, 12, 11};
    logic [4:0] wc;
    for (int k = 0; k < 4; k++) begin
      wc = 5'(k * 9);
      msg(16'h0, 1'b0, k[0], wc, 2, -1, 1'b0, 16'h0, 4'h8 >> k);
      rec(fl(fb[k]) | fl(rxmi_pkg::B_MSG_ERR) | fl(rxmi_pkg::B_BUS_SEL) * k[0] | wc, 2);
    end
  endtask : t_faults

  task automatic t_busy();
    for (int k = 0; k < 2; k++) begin
      wr(rxmi_pkg::OFS_CTRL, 32'(k == 0));
      wr(rxmi_pkg::OFS_BUSY_TBL, 32'(k == 1) << 3);
      msg(16'h0, 1'b0, 1'b0, 5'h03, 3, -1, 1'b0, 16'h0, 4'h0);
      rec(fl(rxmi_pkg::B_BUSY) | 16'h3, 3);
    end
    wr(rxmi_pkg::OFS_BUSY_TBL, 32'h0);
    wr(rxmi_pkg::OFS_ILLEGAL, 32'h8);
    msg(16'h0, 1'b0, 1'b0, 5'h03, 3, -1, 1'b0, 16'h0, 4'h0);
    rec(fl(rxmi_pkg::B_ILLEGAL) | 16'h3, 3);
    wr(rxmi_pkg::OFS_ILLEGAL, 32'h0);
  endtask : t_busy

  task automatic t_rt_to_rt();
    logic [15:0] c2s [7] = '{cw(5'h1f, 1'b1, 5'h04, 5'h03), cw(5'h09, 1'b0, 5'h04, 5'h03),
      cw(5'h09, 1'b1, 5'h00, 5'h03), cw(5'h09, 1'b1, 5'h1f, 5'h03),
      cw(5'h05, 1'b1, 5'h04, 5'h03), cw(5'h09, 1'b1, 5'h04, 5'h03),
      cw(5'h09, 1'b1, 5'h04, 5'h03)};
    logic [15:0] sws [7] = '{16'h4800, 16'h4800, 16'h4800, 16'h4800, 16'h2800, 16'h4800,
      16'h5000};
    msg(c2s[5], 1'b1, 1'b0, 5'h03, 3, -1, 1'b1, 16'h4800, 4'h0);
    rec(fl(rxmi_pkg::B_RT_TO_RT) | 16'h3, 3);
    for (int k = 0; k < 7; k++) begin
      msg(c2s[k], 1'b1, 1'b0, 5'h03, 3, -1, k != 5, sws[k], 4'h0);
      rec(fl(rxmi_pkg::B_TX_ERR) | fl(rxmi_pkg::B_MSG_ERR) | 16'h3, 0);
    end
  endtask : t_rt_to_rt

  // Reset in mid-run returns control, message count, irq and mem_we to zero
  task automatic t_reset();
    wr(rxmi_pkg::OFS_CTRL, 32'h1);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(rxmi_pkg::OFS_CTRL, 32'h0);
    rdc(rxmi_pkg::OFS_MSG_COUNT, 32'h0);
    check("irq", irq, 1'b0);
    check("mem_we", mem_we, 1'b0);
  endtask : t_reset

  task automatic t_irq();
    logic [31:0] r;
    ahb(1'b0, rxmi_pkg::OFS_IRQ_STAT, 32'h0, r);
    wr(rxmi_pkg::OFS_IRQ_MASK, 32'h2);
    msg(16'h0, 1'b0, 1'b0, 5'h03, 3, -1, 1'b0, 16'h0, 4'h0);
    check("irq", irq, 1'b0);
    msg(16'h0, 1'b0, 1'b0, 5'h04, 4, 1, 1'b0, 16'h0, 4'h0);
    rec(fl(rxmi_pkg::B_INVALID_WORD) | fl(rxmi_pkg::B_MSG_ERR) | 16'h4, 1);
    check("irq", irq, 1'b1);
    rdc(rxmi_pkg::OFS_IRQ_STAT, 32'h3);
    repeat (2) @(posedge hclk);
    check("irq", irq, 1'b0);
  endtask : t_irq

  // Reset, then every scenario in turn
  initial begin
    {hresetn, hsel, htrans, haddr, hwrite, hwdata} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(rxmi_pkg::OFS_CTRL, 32'h0);
    rdc(rxmi_pkg::OFS_IRQ_MASK, 32'h0);
    t_plain();
    t_faults();
    t_busy();
    t_rt_to_rt();
    t_irq();
    t_reset();
    test_done();
  end

  // Watchdog
  initial begin
    #400000;
    fail_count++;
    test_done();
  end
endmodule : test_rxmi_top
